// ### hw/nvs_pkg.sv
package nvs_pkg;

  // Clock rate and background cycle times
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned EE_CYCLE_US = 2000;
  localparam int unsigned FL_CYCLE_US = 2000;
  localparam int unsigned EE_CYCLE_CYC = CLK_HZ / 1_000_000 * EE_CYCLE_US;
  localparam int unsigned FL_CYCLE_CYC = CLK_HZ / 1_000_000 * FL_CYCLE_US;

  // Register indices; byte address is four times the index
  localparam logic [10:0] IDX_CONTROL = 11'h760;
  localparam logic [10:0] IDX_ADDR_LOW = 11'h762;
  localparam logic [10:0] IDX_ADDR_HIGH = 11'h764;
  localparam logic [10:0] IDX_KEY = 11'h766;
  localparam logic [10:0] IDX_STATUS = 11'h768;

  // Control and status field positions and reset values
  localparam int unsigned BIT_GO = 15;
  localparam int unsigned BIT_MODIFY = 14;
  localparam int unsigned BIT_ABORT = 13;
  localparam int unsigned BIT_FLAG8 = 8;
  localparam int unsigned BIT_DONE = 0;
  localparam int unsigned BIT_BUSY = 1;
  localparam logic [6:0] OP_RESET = 7'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // Unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Operation select codes
  localparam logic [6:0] OP_EE_WORD_ERASE = 7'h44;
  localparam logic [6:0] OP_EE_BLOCK_ERASE = 7'h45;
  localparam logic [6:0] OP_EE_WORD_PROG = 7'h04;
  localparam logic [6:0] OP_EE_BLOCK_PROG = 7'h05;
  localparam logic [6:0] OP_FL_ROW_ERASE = 7'h41;
  localparam logic [6:0] OP_FL_ROW_PROG = 7'h01;

  // Data EEPROM map
  localparam logic [23:0] EE_BASE = 24'h7FFC00;
  localparam int unsigned EE_WORDS = 512;
  localparam int unsigned BLOCK_WORDS = 16;
  localparam logic [3:0] BLOCK_LAST = 4'hF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT_FIRST = 2'b01,
    KEY_ARMED = 2'b10
  } nvs_key_t;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_TIMING = 2'b01,
    CYC_COMMIT = 2'b10
  } nvs_cyc_t;

endpackage

// ### hw/nvs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

module nvs_sequencer #(
  parameter int unsigned EE_CYCLES = nvs_pkg::EE_CYCLE_CYC,
  parameter int unsigned FL_CYCLES = nvs_pkg::FL_CYCLE_CYC
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic power_on,
  // Reset causes that abort a cycle
  input wire logic master_clear_pin_n,
  input wire logic watchdog_timer_reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [12:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Table access port
  input wire logic tbl_req,
  input wire logic tbl_we,
  input wire logic [7:0] table_page,
  input wire logic [15:0] tbl_ptr,
  input wire logic [15:0] tbl_wdata,
  output logic [15:0] tbl_rdata,
  // Status outputs
  output logic done_interrupt_flag,
  output logic cycle_busy,
  output logic cpu_stall
);

  // True when page and pointer fall inside the data EEPROM
  function automatic logic in_ee(input logic [7:0] page, input logic [15:0] ptr);
    logic [23:0] full;
    full = {page, ptr};
    return full[23:10] == nvs_pkg::EE_BASE[23:10];
  endfunction

  // Word index inside the data EEPROM
  function automatic logic [8:0] ee_index(input logic [15:0] ptr);
    return ptr[9:1];
  endfunction

  logic [15:0] ee_mem [nvs_pkg::EE_WORDS];
  logic [15:0] wr_latch [nvs_pkg::BLOCK_WORDS];

  logic [31:0] dat_reg, dat_next;
  logic ack_reg, ack_next;
  nvs_pkg::nvs_key_t key_reg, key_next;
  nvs_pkg::nvs_cyc_t cyc_reg, cyc_next;
  logic go_reg, go_next;
  logic modify_reg, modify_next;
  logic flag8_reg, flag8_next;
  logic [6:0] op_reg, op_next;
  logic [6:0] cur_op_reg, cur_op_next;
  logic [31:0] timer_reg, timer_next;
  logic [3:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic stall_reg, stall_next;
  logic abort_reg, abort_next;
  logic [15:0] addr_lo_reg, addr_lo_next;
  logic [7:0] addr_hi_reg, addr_hi_next;
  logic master_clear_pin_meta_reg, master_clear_pin_sync_reg;
  logic [15:0] tbl_rdata_reg;

  logic bus_hit, bus_wr, lo_en, hi_en, abort_evt, finish, start_ok;
  logic [10:0] idx;
  logic [15:0] wdat;
  logic mem_we;
  logic [8:0] mem_idx;
  logic [15:0] mem_wdata;
  logic is_ee_op, is_block, is_erase;

  // Decode of the cycle in progress
  assign is_ee_op = cur_op_reg[2];
  assign is_block = cur_op_reg[0];
  assign is_erase = cur_op_reg[6];

  // Abort causes: synchronised pin and same-domain watchdog request
  assign abort_evt = ~master_clear_pin_sync_reg | watchdog_timer_reset;

  // Next-state logic for bus, unlock, control and cycle sequencing
  always_comb begin
    bus_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
    bus_wr = bus_hit & wb_we_i;
    idx = wb_adr_i[12:2];
    lo_en = wb_sel_i[0];
    hi_en = wb_sel_i[1];
    wdat = wb_dat_i[15:0];
    ack_next = bus_hit;
    dat_next = 32'h0000_0000;
    key_next = key_reg;
    cyc_next = cyc_reg;
    go_next = go_reg;
    modify_next = modify_reg;
    flag8_next = flag8_reg;
    op_next = op_reg;
    cur_op_next = cur_op_reg;
    timer_next = timer_reg;
    cnt_next = cnt_reg;
    done_next = done_reg;
    abort_next = abort_reg;
    addr_lo_next = addr_lo_reg;
    addr_hi_next = addr_hi_reg;
    mem_we = 1'b0;
    mem_idx = 9'h000;
    mem_wdata = nvs_pkg::ERASED_WORD;
    finish = 1'b0;
    start_ok = 1'b0;
    // Read mux; unmapped addresses answer zero
    if (bus_hit && !wb_we_i) begin
      unique case (idx)
        nvs_pkg::IDX_CONTROL: dat_next[15:0] = {go_reg, modify_reg, abort_reg, 4'h0,
                                                flag8_reg, 1'b0, op_reg};
        nvs_pkg::IDX_ADDR_LOW: dat_next[15:0] = addr_lo_reg;
        nvs_pkg::IDX_ADDR_HIGH: dat_next[15:0] = {8'h00, addr_hi_reg};
        nvs_pkg::IDX_STATUS: dat_next[15:0] = {14'h0000, cyc_reg != nvs_pkg::CYC_IDLE,
                                               done_reg};
        default: dat_next = 32'h0000_0000;
      endcase
    end
    // Unlock sequencer: any other write drops the unlock
    if (bus_wr) begin
      if (idx == nvs_pkg::IDX_KEY && lo_en) begin
        if (wdat[7:0] == nvs_pkg::KEY_FIRST) begin
          key_next = nvs_pkg::KEY_GOT_FIRST;
        end else if (wdat[7:0] == nvs_pkg::KEY_SECOND && key_reg == nvs_pkg::KEY_GOT_FIRST) begin
          key_next = nvs_pkg::KEY_ARMED;
        end else begin
          key_next = nvs_pkg::KEY_IDLE;
        end
      end else begin
        key_next = nvs_pkg::KEY_IDLE;
      end
    end
    // Control and address register writes
    if (bus_wr && idx == nvs_pkg::IDX_CONTROL) begin
      if (lo_en) begin
        op_next = wdat[6:0];
      end
      if (hi_en) begin
        modify_next = wdat[nvs_pkg::BIT_MODIFY];
        flag8_next = wdat[nvs_pkg::BIT_FLAG8];
        if (!wdat[nvs_pkg::BIT_ABORT]) begin
          abort_next = 1'b0;
        end
        // Go needs old modify enable, armed key, idle engine, known operation
        start_ok = wdat[nvs_pkg::BIT_GO] && modify_reg
                   && key_reg == nvs_pkg::KEY_ARMED
                   && cyc_reg == nvs_pkg::CYC_IDLE
                   && (op_reg == nvs_pkg::OP_FL_ROW_ERASE || op_reg == nvs_pkg::OP_FL_ROW_PROG
                   || ((op_reg == nvs_pkg::OP_EE_WORD_ERASE || op_reg == nvs_pkg::OP_EE_BLOCK_ERASE
                   || op_reg == nvs_pkg::OP_EE_WORD_PROG || op_reg == nvs_pkg::OP_EE_BLOCK_PROG)
                   && in_ee(addr_hi_reg, addr_lo_reg)));
      end
    end
    if (bus_wr && idx == nvs_pkg::IDX_ADDR_LOW) begin
      if (lo_en) begin
        addr_lo_next[7:0] = wdat[7:0];
      end
      if (hi_en) begin
        addr_lo_next[15:8] = wdat[15:8];
      end
    end
    if (bus_wr && idx == nvs_pkg::IDX_ADDR_HIGH && lo_en) begin
      addr_hi_next = wdat[7:0];
    end
    // Table latch writes capture the address of the last access
    if (tbl_req && tbl_we && in_ee(table_page, tbl_ptr)) begin
      addr_lo_next = tbl_ptr;
      addr_hi_next = table_page;
    end
    // Cycle engine
    unique case (cyc_reg)
      nvs_pkg::CYC_IDLE: begin
        if (start_ok) begin
          go_next = 1'b1;
          cur_op_next = op_reg;
          cyc_next = nvs_pkg::CYC_TIMING;
          timer_next = op_reg[2] ? EE_CYCLES : FL_CYCLES;
          cnt_next = 4'h0;
        end
      end
      nvs_pkg::CYC_TIMING: begin
        timer_next = timer_reg - 32'h0000_0001;
        if (timer_reg <= 32'h0000_0001) begin
          if (is_ee_op) begin
            cyc_next = nvs_pkg::CYC_COMMIT;
          end else begin
            finish = 1'b1;
          end
        end
      end
      nvs_pkg::CYC_COMMIT: begin
        // One word per cycle; block ops walk the aligned 16-word block
        mem_we = 1'b1;
        mem_idx = is_block ? {addr_lo_reg[9:5], cnt_reg} : ee_index(addr_lo_reg);
        mem_wdata = is_erase ? nvs_pkg::ERASED_WORD
                    : wr_latch[is_block ? cnt_reg : addr_lo_reg[4:1]];
        cnt_next = cnt_reg + 4'h1;
        if (!is_block || cnt_reg == nvs_pkg::BLOCK_LAST) begin
          finish = 1'b1;
        end
      end
      default: cyc_next = nvs_pkg::CYC_IDLE;
    endcase
    if (finish) begin
      cyc_next = nvs_pkg::CYC_IDLE;
      go_next = 1'b0;
    end
    // Done flag: write one clears, completion set wins
    if (bus_wr && idx == nvs_pkg::IDX_STATUS && lo_en && wdat[nvs_pkg::BIT_DONE]) begin
      done_next = 1'b0;
    end
    if (finish) begin
      done_next = 1'b1;
    end
    // Reset cause during a cycle aborts it and flags it
    if (abort_evt && cyc_reg != nvs_pkg::CYC_IDLE) begin
      mem_we = 1'b0;
      done_next = done_reg;
      cyc_next = nvs_pkg::CYC_IDLE;
      go_next = 1'b0;
      abort_next = 1'b1;
    end
    stall_next = cyc_next != nvs_pkg::CYC_IDLE && !cur_op_next[2];
  end

  // Registers cleared by system reset
  always_ff @(posedge clk_sys) begin
    if (reset || power_on) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      key_reg <= nvs_pkg::KEY_IDLE;
      cyc_reg <= nvs_pkg::CYC_IDLE;
      go_reg <= 1'b0;
      modify_reg <= 1'b0;
      flag8_reg <= 1'b0;
      op_reg <= nvs_pkg::OP_RESET;
      cur_op_reg <= nvs_pkg::OP_RESET;
      timer_reg <= 32'h0000_0000;
      cnt_reg <= 4'h0;
      done_reg <= 1'b0;
      stall_reg <= 1'b0;
    end else if (clk_en) begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      key_reg <= key_next;
      cyc_reg <= cyc_next;
      go_reg <= go_next;
      modify_reg <= modify_next;
      flag8_reg <= flag8_next;
      op_reg <= op_next;
      cur_op_reg <= cur_op_next;
      timer_reg <= timer_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      stall_reg <= stall_next;
    end
  end

  // Registers that survive system reset; only power-on initialises them
  always_ff @(posedge clk_sys) begin
    if (power_on) begin
      abort_reg <= 1'b0;
      addr_lo_reg <= nvs_pkg::ADDR_RESET;
      addr_hi_reg <= nvs_pkg::ADDR_RESET[7:0];
      master_clear_pin_meta_reg <= 1'b1;
      master_clear_pin_sync_reg <= 1'b1;
    end else if (clk_en) begin
      abort_reg <= abort_next;
      addr_lo_reg <= addr_lo_next;
      addr_hi_reg <= addr_hi_next;
      master_clear_pin_meta_reg <= master_clear_pin_n;
      master_clear_pin_sync_reg <= master_clear_pin_meta_reg;
    end
  end

  // Memory array, write latches and table read port
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (mem_we) begin
        ee_mem[mem_idx] <= mem_wdata;
      end
      if (tbl_req && tbl_we && in_ee(table_page, tbl_ptr)) begin
        wr_latch[tbl_ptr[4:1]] <= tbl_wdata;
      end
      if (tbl_req && !tbl_we) begin
        tbl_rdata_reg <= in_ee(table_page, tbl_ptr) ? ee_mem[ee_index(tbl_ptr)]
                         : 16'h0000;
      end
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign tbl_rdata = tbl_rdata_reg;
  assign done_interrupt_flag = done_reg;
  assign cycle_busy = go_reg;
  assign cpu_stall = stall_reg;

endmodule

`default_nettype wire

// ### tb/nvs_sequencer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module nvs_chk #(
  parameter int unsigned EE_CYCLES = 20,
  parameter int unsigned FL_CYCLES = 20
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic power_on,
  input wire logic clk_en,
  // Abort causes
  input wire logic master_clear_pin_n,
  input wire logic watchdog_timer_reset,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [12:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Status
  input wire logic done_interrupt_flag,
  input wire logic cycle_busy,
  input wire logic cpu_stall
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset || power_on);
  logic [31:0] busy_cnt_reg;
  logic [31:0] busy_cnt_next;
  logic [2:0] abort_cnt_reg;
  logic [2:0] abort_cnt_next;
  logic go_wr;
  logic clr_wr;
  // Length of the current busy window, counted in enabled cycles only
  always_comb begin
    busy_cnt_next = cycle_busy ? busy_cnt_reg + {31'h0000_0000, clk_en} : 32'h0000_0000;
  end
  // Recent abort cause; covers the pin synchroniser delay
  always_comb begin
    if (watchdog_timer_reset || !master_clear_pin_n) begin
      abort_cnt_next = 3'h4;
    end else if (abort_cnt_reg != 3'h0) begin
      abort_cnt_next = abort_cnt_reg - 3'h1;
    end else begin
      abort_cnt_next = 3'h0;
    end
  end
  always_ff @(posedge clk_sys) begin
    busy_cnt_reg <= (reset || power_on) ? 32'h0000_0000 : busy_cnt_next;
    abort_cnt_reg <= power_on ? 3'h0 : abort_cnt_next;
  end
  // Go and done-clear writes being taken
  assign go_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[1] && wb_dat_i[15]
    && (wb_adr_i[12:2] == nvs_pkg::IDX_CONTROL);
  assign clr_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_dat_i[0]
    && (wb_adr_i[12:2] == nvs_pkg::IDX_STATUS);
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_finish;
    $fell(cycle_busy) && abort_cnt_reg == 3'h0;
  endsequence
  a_ack_answer: assert property (s_taken |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack cycle");
  a_go_cause: assert property ($rose(cycle_busy) |-> $past(go_wr))
    else $error("cycle started without a go write");
  a_ee_length: assert property (s_finish ##0 !$past(cpu_stall) |->
    busy_cnt_reg >= EE_CYCLES && busy_cnt_reg <= EE_CYCLES + 17)
    else $error("eeprom cycle length wrong");
  a_fl_length: assert property (s_finish ##0 $past(cpu_stall) |->
    busy_cnt_reg >= FL_CYCLES && busy_cnt_reg <= FL_CYCLES + 2)
    else $error("flash cycle length wrong");
  a_done_finish: assert property (s_finish |-> done_interrupt_flag)
    else $error("done not set at completion");
  a_done_sticky: assert property (done_interrupt_flag && !clr_wr |=> done_interrupt_flag)
    else $error("done flag lost without clear");
  a_done_cause: assert property ($rose(done_interrupt_flag) |-> $fell(cycle_busy))
    else $error("done rose without completion");
  a_stall_busy: assert property (cpu_stall |-> cycle_busy)
    else $error("stall outside a cycle");
  a_abort_stop: assert property (watchdog_timer_reset && cycle_busy && clk_en |=> !cycle_busy)
    else $error("cycle not stopped by watchdog reset");
endmodule
bind nvs_sequencer nvs_chk #(.EE_CYCLES(EE_CYCLES), .FL_CYCLES(FL_CYCLES)) i_chk (.clk_sys,
  .reset, .power_on, .clk_en, .master_clear_pin_n, .watchdog_timer_reset,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .done_interrupt_flag, .cycle_busy, .cpu_stall);
`default_nettype wire

// ### tb/nvs_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module nvs_sequencer_bench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic power_on = 1'b1;
  logic master_clear_pin_n = 1'b1;
  logic watchdog_timer_reset = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [12:0] wb_adr_i = 13'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic tbl_req = 1'b0;
  logic tbl_we = 1'b0;
  logic [7:0] table_page = 8'h00;
  logic [15:0] tbl_ptr = 16'h0000;
  logic [15:0] tbl_wdata = 16'h0000;
  logic [15:0] tbl_rdata;
  logic done_interrupt_flag;
  logic cycle_busy;
  logic cpu_stall;
  logic [15:0] rd;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int i;
  // Short cycle times keep the run brief
  nvs_sequencer #(.EE_CYCLES(20), .FL_CYCLES(20)) i_dut (.clk_sys, .reset, .clk_en, .power_on,
    .master_clear_pin_n, .watchdog_timer_reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tbl_req, .tbl_we, .table_page, .tbl_ptr,
    .tbl_wdata, .tbl_rdata, .done_interrupt_flag, .cycle_busy, .cpu_stall);
  always #25 clk_sys = ~clk_sys;
  task automatic stop_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Cycle ceiling against a hung run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic Wishbone single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [10:0] idx, input logic [15:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdc(input logic [10:0] idx, input logic [15:0] m, input logic [15:0] exp);
    wb(1'b0, idx, 16'h0000);
    chk(rd & m, exp);
  endtask
  // One table access pulse in the EEPROM page
  task automatic tacc(input logic we, input logic [15:0] ptr, input logic [15:0] d);
    @(posedge clk_sys);
    tbl_req <= 1'b1;
    tbl_we <= we;
    table_page <= 8'h7F;
    tbl_ptr <= ptr;
    tbl_wdata <= d;
    @(posedge clk_sys);
    tbl_req <= 1'b0;
    @(negedge clk_sys);
    rd = tbl_rdata;
  endtask
  // Operation setup, key pair, then go as the next write
  task automatic start(input logic [6:0] op);
    wb(1'b1, nvs_pkg::IDX_CONTROL, {9'h080, op});
    wb(1'b1, nvs_pkg::IDX_KEY, 16'h0055);
    wb(1'b1, nvs_pkg::IDX_KEY, 16'h00AA);
    wb(1'b1, nvs_pkg::IDX_CONTROL, {9'h180, op});
    repeat (2) @(posedge clk_sys);
  endtask
  // Wait out a cycle, then see and clear the done flag
  task automatic finish();
    do begin
      @(negedge clk_sys);
    end while (cycle_busy === 1'b1);
    chk({15'h0000, done_interrupt_flag}, 16'h0001);
    rdc(nvs_pkg::IDX_STATUS, 16'h0003, 16'h0001);
    wb(1'b1, nvs_pkg::IDX_STATUS, 16'h0001);
    chk({15'h0000, done_interrupt_flag}, 16'h0000);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    power_on <= 1'b0;
    rdc(nvs_pkg::IDX_CONTROL, 16'hFFFF, 16'h0000);
    rdc(nvs_pkg::IDX_KEY, 16'hFFFF, 16'h0000);
    rdc(11'h7FF, 16'hFFFF, 16'h0000);
    tacc(1'b1, 16'hFC20, 16'h1234);
    rdc(nvs_pkg::IDX_ADDR_LOW, 16'hFFFF, 16'hFC20);
    rdc(nvs_pkg::IDX_ADDR_HIGH, 16'h00FF, 16'h007F);
    // Refused: no keys, reversed keys, modify clear, keys split by a write
    for (i = 0; i < 4; i++) begin
      wb(1'b1, nvs_pkg::IDX_CONTROL, (i == 2) ? 16'h0044 : 16'h4044);
      if (i > 0) wb(1'b1, nvs_pkg::IDX_KEY, (i == 1) ? 16'h00AA : 16'h0055);
      if (i == 3) wb(1'b1, nvs_pkg::IDX_ADDR_HIGH, 16'h007F);
      if (i > 0) wb(1'b1, nvs_pkg::IDX_KEY, (i == 1) ? 16'h0055 : 16'h00AA);
      wb(1'b1, nvs_pkg::IDX_CONTROL, 16'hC044);
      chk({15'h0000, cycle_busy}, 16'h0000);
    end
    start(7'h44);
    chk({15'h0000, cycle_busy}, 16'h0001);
    wb(1'b1, nvs_pkg::IDX_CONTROL, 16'h4044);
    rdc(nvs_pkg::IDX_CONTROL, 16'h8000, 16'h8000);
    chk({15'h0000, cpu_stall}, 16'h0000);
    finish();
    tacc(1'b0, 16'hFC20, 16'h0000);
    chk(rd, 16'hFFFF);
    start(7'h04);
    finish();
    tacc(1'b0, 16'hFC20, 16'h0000);
    chk(rd, 16'h1234);
    start(7'h45);
    finish();
    tacc(1'b0, 16'hFC3E, 16'h0000);
    chk(rd, 16'hFFFF);
    for (i = 0; i < 16; i++) tacc(1'b1, 16'hFC20 + 16'(2 * i), 16'hA500 + 16'(i));
    start(7'h05);
    finish();
    for (i = 0; i < 16; i++) begin
      tacc(1'b0, 16'hFC20 + 16'(2 * i), 16'h0000);
      chk(rd, 16'hA500 + 16'(i));
    end
    start(7'h41);
    chk({15'h0000, cpu_stall}, 16'h0001);
    // Freeze longer than a whole cycle; the cycle must still be running
    clk_en <= 1'b0;
    repeat (25) @(posedge clk_sys);
    chk({14'h0000, cycle_busy, cpu_stall}, 16'h0003);
    clk_en <= 1'b1;
    finish();
    // Abort by watchdog, then by the pin, with reset following
    for (i = 0; i < 2; i++) begin
      start(7'h44);
      if (i == 0) watchdog_timer_reset <= 1'b1;
      else master_clear_pin_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b1;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      watchdog_timer_reset <= 1'b0;
      master_clear_pin_n <= 1'b1;
      rdc(nvs_pkg::IDX_CONTROL, 16'hFFFF, 16'h2000);
      rdc(nvs_pkg::IDX_ADDR_LOW, 16'hFFFF, 16'hFC3E);
      chk({15'h0000, done_interrupt_flag}, 16'h0000);
      wb(1'b1, nvs_pkg::IDX_CONTROL, 16'h0000);
      rdc(nvs_pkg::IDX_CONTROL, 16'hFFFF, 16'h0000);
    end
    wb(1'b1, nvs_pkg::IDX_CONTROL, 16'h4000);
    @(posedge clk_sys);
    power_on <= 1'b1;
    @(posedge clk_sys);
    power_on <= 1'b0;
    rdc(nvs_pkg::IDX_ADDR_LOW, 16'hFFFF, 16'h0000);
    rdc(nvs_pkg::IDX_CONTROL, 16'hFFFF, 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
